// File: bench/pmau_phy_model.sv
`timescale 1ns/10ps
module pmau_phy_model #(
  parameter logic [4:0] PHY_ADDR = 5'h01
) (
  input  wire logic i_mdc,
  input  wire logic i_mdio,
  output logic      o_mdio_out,
  output logic      o_mdio_oe
);
  logic [15:0] regs [32];
  logic [31:0] sh;
  logic [11:0] hdr;
  logic        rd_q;
  int          ones;
  int          pos;

  // transceiver register file starts cleared, line released
  initial begin
    o_mdio_out = 1'b0;
    o_mdio_oe = 1'b0;
    ones = 0;
    pos = -1;
    rd_q = 1'b0;
    foreach (regs[i]) regs[i] = 16'h0000;
  end

  // decode frames on clock rises, answer reads after the turnaround
  always @(posedge i_mdc) begin
    sh = {sh[30:0], i_mdio};
    if (pos < 0) begin
      if (!i_mdio && ones >= 32) pos = 33;
      ones = i_mdio ? ones + 1 : 0;
    end else begin
      if (pos == 45) begin
        hdr = sh[11:0];
        rd_q = (hdr[11:10] == 2'h2) && (hdr[9:5] == PHY_ADDR);
      end
      if (pos == 46 && rd_q) begin
        o_mdio_oe <= 1'b1;
        o_mdio_out <= 1'b0;
      end
      if (pos >= 47 && pos < 63 && rd_q)
        o_mdio_out <= regs[hdr[4:0]][62 - pos];
      if (pos == 63) begin
        o_mdio_oe <= 1'b0;
        if (hdr[11:10] == 2'h1 && hdr[9:5] == PHY_ADDR)
          regs[hdr[4:0]] = sh[15:0];
        pos = -1;
        ones = 0;
      end else begin
        pos = pos + 1;
      end
    end
  end
endmodule

// File: bench/test_phy_mgmt_access_unit.sv
`timescale 1ns/10ps
module test_phy_mgmt_access_unit;
  import pmau_pkg::*;
  localparam logic [7:0] ACC_A  = 8'(ACC_INDEX * 4);
  localparam logic [7:0] DATA_A = 8'(DATA_INDEX * 4);
  logic        i_core_clk, i_reset, i_psel, i_penable, i_pwrite;
  logic [7:0]  i_paddr;
  logic [31:0] i_pwdata, o_prdata, rd;
  logic        o_pready, o_pslverr, o_mdc, o_mdio_out, o_mdio_oe;
  logic        phy_out, phy_oe, err, mdio;
  int          n_fail, total_checks, rises, polls;

  // shared line with pull-up when nobody drives
  assign mdio = o_mdio_oe ? o_mdio_out : (phy_oe ? phy_out : 1'b1);

  pmau_top #(.ADDR_W(8)) pmau_top_i (
    .i_core_clk, .i_reset, .i_psel, .i_penable, .i_pwrite, .i_paddr,
    .i_pwdata, .o_prdata, .o_pready, .o_pslverr, .i_mdio_in(mdio),
    .o_mdc, .o_mdio_out, .o_mdio_oe
  );
  pmau_phy_model pmau_phy_model_i (
    .i_mdc(o_mdc), .i_mdio(mdio), .o_mdio_out(phy_out), .o_mdio_oe(phy_oe)
  );

  // core clock
  initial begin
    i_core_clk = 1'b0;
    forever #10 i_core_clk = ~i_core_clk;
  end

  // count management clock rises
  always @(posedge o_mdc) rises++;

  task automatic chk(input string nm, input logic [31:0] e, g);
    total_checks++;
    if (g !== e) begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask

  // one apb transfer, entered right after a rising edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    i_psel <= 1'b1;
    i_pwrite <= w;
    i_paddr <= a;
    i_pwdata <= d;
    @(posedge i_core_clk);
    i_penable <= 1'b1;
    do begin
      @(posedge i_core_clk);
      n++;
    end while (o_pready !== 1'b1 && n < 20);
    if (n >= 20) n_fail++;
    rd = o_prdata;
    err = o_pslverr;
    i_psel <= 1'b0;
    i_penable <= 1'b0;
    @(posedge i_core_clk);
  endtask

  task automatic wait_idle();
    polls = 0;
    do begin
      apb(1'b0, ACC_A, 32'h0);
      polls++;
    end while (rd[0] !== 1'b0 && polls < 600);
    if (polls >= 600) n_fail++;
  endtask

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  // watchdog against a hung handshake or frame
  initial begin
    #(20 * 20000);
    n_fail++;
    wrap_up();
  end

  // main sequence
  initial begin
    {i_reset, i_psel, i_penable, i_pwrite} = 4'h8;
    i_paddr = 8'h00;
    i_pwdata = 32'h0;
    {n_fail, total_checks, rises} = '0;
    repeat (2) @(posedge i_core_clk);
    i_reset <= 1'b0;
    @(posedge i_core_clk);
    apb(1'b0, ACC_A, 32'h0); chk("acc reset", 32'h0, rd);
    apb(1'b0, DATA_A, 32'h0); chk("data reset", 32'h0, rd);
    apb(1'b1, 8'h20, 32'hFFFFFFFF);
    chk("unmapped err", 32'h1, {31'h0, err});
    apb(1'b0, 8'h20, 32'h0); chk("unmapped data", 32'h0, rd);
    $display("test reset and map done");
    apb(1'b1, DATA_A, 32'hFFFF1234);
    apb(1'b0, DATA_A, 32'h0); chk("data rsvd", 32'h1234, rd);
    apb(1'b1, ACC_A, 32'hFFFF097E);
    repeat (40) @(posedge i_core_clk);
    chk("no frame", 32'h0, rises);
    apb(1'b0, ACC_A, 32'h0); chk("acc fields", 32'h942, rd);
    $display("test fields done");
    apb(1'b1, ACC_A, 32'h00000943);
    apb(1'b0, ACC_A, 32'h0); chk("busy set", 32'h1, {31'h0, rd[0]});
    wait_idle();
    chk("busy span", 32'h1, {31'h0, polls > 305 && polls < 330});
    chk("phy write", 32'h1234, {16'h0, pmau_phy_model_i.regs[5]});
    chk("frame bits", 32'd64, rises);
    apb(1'b0, DATA_A, 32'h0); chk("data kept", 32'h1234, rd);
    $display("test write frame done");
    pmau_phy_model_i.regs[9] = 16'hA5C3;
    apb(1'b1, ACC_A, 32'h00000A41);
    apb(1'b1, DATA_A, 32'h00005555);
    wait_idle();
    chk("acc after read", 32'hA40, rd);
    apb(1'b0, DATA_A, 32'h0); chk("read frame", 32'hA5C3, rd);
    chk("frame bits", 32'd128, rises);
    $display("test read frame done");
    wrap_up();
  end
endmodule

// File: src/pmau_pkg.sv
package pmau_pkg;

  // register indices; byte address is four times the index
  localparam int unsigned ACC_INDEX  = 6;
  localparam int unsigned DATA_INDEX = 7;

  // access register field positions
  localparam int unsigned PHYAD_LSB = 11;
  localparam int unsigned REGIX_LSB = 6;
  localparam int unsigned WNR_BIT   = 1;
  localparam int unsigned BUSY_BIT  = 0;
  localparam int unsigned FIELD_W   = 5;
  localparam int unsigned DATA_W    = 16;

  // values after reset
  localparam logic [4:0]  PHYAD_RESET = 5'h00;
  localparam logic [4:0]  REGIX_RESET = 5'h00;
  localparam logic [15:0] DATA_RESET  = 16'h0000;

  // management clock timing
  localparam int unsigned CLK_PERIOD_NS  = 20;
  localparam int unsigned MDC_PERIOD_NS  = 400;
  localparam int unsigned MDC_PERIOD_CYC =
    (MDC_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned MDC_HALF_CYC   = (MDC_PERIOD_CYC + 1) / 2;

  // management frame layout
  localparam int unsigned FRAME_BITS  = 64;
  localparam int unsigned FRM_OP_LSB  = 28;
  localparam int unsigned FRM_PHY_LSB = 23;
  localparam int unsigned FRM_REG_LSB = 18;
  localparam logic [31:0] PREAMBLE    = 32'hFFFFFFFF;
  localparam logic [1:0]  FRM_START   = 2'h1;
  localparam logic [1:0]  OP_WRITE    = 2'h1;
  localparam logic [1:0]  OP_READ     = 2'h2;
  localparam logic [1:0]  TA_WRITE    = 2'h2;
  localparam logic [5:0]  LAST_BIT    = 6'h3F;
  localparam logic [5:0]  TURN_BIT    = 6'h2E;
  localparam logic [5:0]  RDATA_BIT   = 6'h30;

  // longest busy window, used by checks
  localparam int unsigned BUSY_MAX_CYC = FRAME_BITS * MDC_HALF_CYC * 2 + 2;

  typedef enum logic {MG_IDLE, MG_SHIFT} pmau_state_t;

endpackage

// File: src/pmau_tick_div.sv
`timescale 1ns/10ps
module pmau_tick_div #(
  parameter int unsigned HALF = 10
) (
  input  wire logic i_core_clk,
  input  wire logic i_reset,
  input  wire logic i_clear,
  output logic      o_tick
);

  localparam int unsigned CW = (HALF > 1) ? $clog2(HALF) : 1;

  logic [CW-1:0] cnt_q;

  // one-cycle enable every HALF clocks, restartable
  always_ff @(posedge i_core_clk) begin
    if (i_reset || i_clear) begin
      cnt_q  <= '0;
      o_tick <= 1'b0;
    end else if (cnt_q == CW'(HALF - 1)) begin
      cnt_q  <= '0;
      o_tick <= 1'b1;
    end else begin
      cnt_q  <= cnt_q + CW'(1);
      o_tick <= 1'b0;
    end
  end

endmodule

// File: src/pmau_top.sv
`timescale 1ns/10ps
module pmau_top #(
  parameter int unsigned ADDR_W = 8
) (
  input  wire logic              i_core_clk,
  input  wire logic              i_reset,
  input  wire logic              i_psel,
  input  wire logic              i_penable,
  input  wire logic              i_pwrite,
  input  wire logic [ADDR_W-1:0] i_paddr,
  input  wire logic [31:0]       i_pwdata,
  output logic      [31:0]       o_prdata,
  output logic                   o_pready,
  output logic                   o_pslverr,
  input  wire logic              i_mdio_in,
  output logic                   o_mdc,
  output logic                   o_mdio_out,
  output logic                   o_mdio_oe
);

  import pmau_pkg::*;

  logic [4:0]          phy_addr_q;
  logic [4:0]          reg_index_q;
  logic                write_not_read_q;
  logic                mgmt_busy_q;
  logic [15:0]         data_q;
  pmau_state_t         state_q;
  logic [63:0]         frame_q;
  logic [5:0]          bit_q;
  logic [15:0]         rd_shift_q;
  logic [11:0]         busy_cnt_q;
  logic                apb_done;
  logic                hit_acc;
  logic                hit_data;
  logic                wr_acc;
  logic                wr_data;
  logic                start;
  logic                tick;
  logic                rise_tick;
  logic                fall_tick;
  logic                finish;
  logic [15:0]         pw_low;

  // word address match for a register index
  function automatic logic is_reg(input logic [ADDR_W-1:0] a,
                                  input int unsigned idx);
    return a == ADDR_W'(idx * 4);
  endfunction

  // assemble the serial frame shifted out msb first
  function automatic logic [63:0] build_frame(input logic [4:0]  phy,
                                              input logic [4:0]  idx,
                                              input logic        wnr,
                                              input logic [15:0] wd);
    return {PREAMBLE, FRM_START, wnr ? OP_WRITE : OP_READ, phy, idx,
            TA_WRITE, wnr ? wd : 16'h0000};
  endfunction

  // bus decode; register writes are ignored while busy
  assign apb_done  = i_psel & i_penable & o_pready;
  assign hit_acc   = is_reg(i_paddr, ACC_INDEX);
  assign hit_data  = is_reg(i_paddr, DATA_INDEX);
  assign wr_acc    = apb_done & i_pwrite & hit_acc & ~mgmt_busy_q;
  assign wr_data   = apb_done & i_pwrite & hit_data & ~mgmt_busy_q;
  assign start     = wr_acc & i_pwdata[BUSY_BIT];
  assign pw_low    = i_pwdata[15:0];

  // management clock edges
  assign rise_tick = tick & ~o_mdc & (state_q == MG_SHIFT);
  assign fall_tick = tick & o_mdc & (state_q == MG_SHIFT);
  assign finish    = fall_tick & (bit_q == LAST_BIT);

  pmau_tick_div #(
    .HALF (MDC_HALF_CYC)
  ) u_div (
    .i_core_clk (i_core_clk),
    .i_reset    (i_reset),
    .i_clear    (start),
    .o_tick     (tick)
  );

  // apb handshake: one wait cycle, then ready for one cycle
  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      o_pready  <= 1'b0;
      o_pslverr <= 1'b0;
      o_prdata  <= 32'h00000000;
    end else begin
      o_pready <= i_psel & i_penable & ~o_pready;
      if (i_psel && i_penable && !o_pready) begin
        o_pslverr <= ~(hit_acc | hit_data);
        if (!i_pwrite && hit_acc) begin
          o_prdata <= {16'h0000, phy_addr_q, reg_index_q, 4'h0,
                       write_not_read_q, mgmt_busy_q};
        end else if (!i_pwrite && hit_data) begin
          o_prdata <= {16'h0000, data_q};
        end else begin
          o_prdata <= 32'h00000000;
        end
      end
    end
  end

  // access register fields; reserved bits are not stored
  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      phy_addr_q       <= PHYAD_RESET;
      reg_index_q      <= REGIX_RESET;
      write_not_read_q <= 1'b0;
    end else if (wr_acc) begin
      phy_addr_q       <= i_pwdata[PHYAD_LSB +: FIELD_W];
      reg_index_q      <= i_pwdata[REGIX_LSB +: FIELD_W];
      write_not_read_q <= i_pwdata[WNR_BIT];
    end
  end

  // busy: set by software, cleared by the frame engine
  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      mgmt_busy_q <= 1'b0;
    end else if (start) begin
      mgmt_busy_q <= 1'b1;
    end else if (finish) begin
      mgmt_busy_q <= 1'b0;
    end
  end

  // data register: software write or read result
  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      data_q <= DATA_RESET;
    end else if (wr_data) begin
      data_q <= i_pwdata[DATA_W-1:0];
    end else if (finish && !write_not_read_q) begin
      data_q <= rd_shift_q;
    end
  end

  // frame engine: mdio changes after mdc falls, sampled as mdc rises
  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      state_q    <= MG_IDLE;
      frame_q    <= 64'h0000000000000000;
      bit_q      <= 6'h00;
      o_mdc      <= 1'b0;
      o_mdio_out <= 1'b0;
      o_mdio_oe  <= 1'b0;
    end else begin
      case (state_q)
        MG_IDLE: begin
          if (start) begin
            state_q    <= MG_SHIFT;
            frame_q    <= build_frame(i_pwdata[PHYAD_LSB +: FIELD_W],
                                      i_pwdata[REGIX_LSB +: FIELD_W],
                                      i_pwdata[WNR_BIT], data_q);
            bit_q      <= 6'h00;
            o_mdc      <= 1'b0;
            o_mdio_out <= 1'b1;
            o_mdio_oe  <= 1'b1;
          end
        end
        MG_SHIFT: begin
          if (tick) begin
            o_mdc <= ~o_mdc;
            if (o_mdc) begin
              if (bit_q == LAST_BIT) begin
                state_q    <= MG_IDLE;
                o_mdio_out <= 1'b0;
                o_mdio_oe  <= 1'b0;
              end else begin
                bit_q      <= bit_q + 6'h01;
                frame_q    <= frame_q << 1;
                o_mdio_out <= frame_q[62];
                // release the line from turnaround on for reads
                o_mdio_oe  <= write_not_read_q |
                              ((bit_q + 6'h01) < TURN_BIT);
              end
            end
          end
        end
        default: begin
          state_q <= MG_IDLE;
        end
      endcase
    end
  end

  // collect read data bits on rising mdc
  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      rd_shift_q <= 16'h0000;
    end else if (rise_tick && !write_not_read_q && bit_q >= RDATA_BIT) begin
      rd_shift_q <= {rd_shift_q[14:0], i_mdio_in};
    end
  end

  // busy length counter for checking
  always_ff @(posedge i_core_clk) begin
    if (i_reset || !mgmt_busy_q) begin
      busy_cnt_q <= 12'h000;
    end else if (busy_cnt_q != 12'hFFF) begin
      busy_cnt_q <= busy_cnt_q + 12'h001;
    end
  end

  AST_START_BUSY: assert property (@(posedge i_core_clk) disable iff (i_reset)
    start |=> mgmt_busy_q && state_q == MG_SHIFT)
    else $error("busy not set after start");

  AST_NO_START: assert property (@(posedge i_core_clk) disable iff (i_reset)
    (state_q == MG_IDLE && !start) |=> state_q == MG_IDLE)
    else $error("frame began without start");

  AST_BUSY_SHIFT: assert property (@(posedge i_core_clk) disable iff (i_reset)
    state_q == MG_SHIFT |-> mgmt_busy_q)
    else $error("busy low during frame");

  AST_BUSY_BOUND: assert property (@(posedge i_core_clk) disable iff (i_reset)
    busy_cnt_q <= 12'(BUSY_MAX_CYC))
    else $error("busy held too long");

  AST_FRAME_INDEX: assert property (@(posedge i_core_clk) disable iff (i_reset)
    start |=> frame_q[FRM_REG_LSB +: 5] == reg_index_q)
    else $error("register index missing from frame");

  AST_FRAME_PHY: assert property (@(posedge i_core_clk) disable iff (i_reset)
    start |=> frame_q[FRM_PHY_LSB +: 5] == phy_addr_q)
    else $error("transceiver address missing from frame");

  AST_FRAME_OP: assert property (@(posedge i_core_clk) disable iff (i_reset)
    start |=> frame_q[FRM_OP_LSB +: 2] ==
              (write_not_read_q ? OP_WRITE : OP_READ))
    else $error("wrong opcode in frame");

  AST_READ_LOAD: assert property (@(posedge i_core_clk) disable iff (i_reset)
    (finish && !write_not_read_q) |=> !mgmt_busy_q &&
                                      data_q == $past(rd_shift_q))
    else $error("read data not loaded as busy clears");

  AST_DATA_WR: assert property (@(posedge i_core_clk) disable iff (i_reset)
    wr_data |=> data_q == $past(pw_low))
    else $error("data register write lost");

  AST_RSVD_ZERO: assert property (@(posedge i_core_clk) disable iff (i_reset)
    o_pready |-> o_prdata[31:16] == 16'h0000)
    else $error("reserved bits read nonzero");

  AST_TURN_RELEASE: assert property (@(posedge i_core_clk)
    disable iff (i_reset)
    (state_q == MG_SHIFT && !write_not_read_q && bit_q >= TURN_BIT)
    |-> !o_mdio_oe)
    else $error("line driven during read turnaround");

  AST_MDC_LOW: assert property (@(posedge i_core_clk) disable iff (i_reset)
    $fell(o_mdc) |-> (!o_mdc)[*8])
    else $error("mdc low phase too short");

endmodule
